// ### pkg/serdes_rx_pkg.sv
package serdes_rx_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] STATUS_OFS    = 8'h04;
    localparam logic [7:0] INT_STS_OFS   = 8'h08;
    localparam logic [7:0] INT_MASK_OFS  = 8'h0C;
    localparam logic [7:0] WORD_CNT_OFS  = 8'h10;

    // control register fields
    localparam int CTRL_RESTART_BIT  = 0;
    localparam int CTRL_TX_MUTE_BIT  = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // live status fields
    localparam int ST_LOS_BIT      = 0;
    localparam int ST_POR_BIT      = 1;
    localparam int ST_REF_LOCK_BIT = 2;
    localparam int ST_LOOPBACK_BIT = 3;
    localparam int ST_PRBS_OK_BIT  = 4;
    localparam int ST_PWRDN_BIT    = 5;
    localparam int ST_TEST_BIT     = 6;

    // interrupt event fields
    localparam int EV_LOS_SET_BIT   = 0;
    localparam int EV_LOS_CLR_BIT   = 1;
    localparam int EV_PRBS_FAIL_BIT = 2;
    localparam int EV_POR_DONE_BIT  = 3;
    localparam int EV_W             = 4;
    localparam logic [3:0] INT_MASK_RESET = 4'h0;

    // recovered word clock: one word per twenty serial bits
    localparam int BITS_PER_WORD = 20;
    localparam logic [4:0] WCLK_RISE_CNT = 5'h09;
    localparam logic [4:0] WCLK_LAST_CNT = 5'h13;

    // internal power-on reset duration
    localparam int CLK_PERIOD_NS = 100;
    localparam int POR_TIME_NS   = 1000;
    localparam int POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // failed-lane value forced while signal is lost
    localparam logic [15:0] LOS_WORD = 16'hFFFF;

    typedef enum logic [1:0] {
        PWR_DOWN = 2'b00,
        PWR_POR  = 2'b01,
        PWR_RUN  = 2'b10
    } pwr_state_e;

endpackage

// ### src/serdes_rx_port.sv
// Operation
// R01 - lock_to_ref_n low: receive timing follows reference, data tracking stops, transmit-only.
// R02 - lock_to_ref_n low: receive word, word clock and both flags go high impedance.
// R03 - lock_to_ref_n high: receive timing recovers from incoming serial data.
// R04 - loopback_select high: own transmit serial stream feeds receiver instead of line.
// R05 - serial transmit outputs undriven during loopback, driven normally otherwise; code drives them only in PWR_RUN with CTRL_TX_MUTE_BIT clear.
// R06 - controller keeps loopback_select low in normal operation.
// R07 - prbs_check_enable high: low flag shows valid pseudo-random stream received.
// R08 - low flag high for control character in bits 0-7, low for data.
// R09 - high flag high for control character in bits 8-15, low for data.
// R10 - serial amplitude below loss threshold forces all word bits and flags high.
// R11 - word clock is serial bit rate divided by twenty, aligned with word.
// R12 - word clock held low during internal power-on reset.
// R13 - word valid at word clock rising edge; protocol device captures there.
// R14 - receive word undriven during internal power-on reset.
// R15 - controller leaves factory_test_select unconnected or low.
// R16 - enable rise from power-down passes power-on reset; power-down keeps only detection.
// R17 - reference word clock supplied continuously within 80 to 135 MHz.
// R18 - loss override outranks control-character and pseudo-random indication.
module serdes_rx_port
    import serdes_rx_pkg::*;
#(
    parameter int POR_LEN = POR_CYCLES
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    // mode pins
    input  wire logic        device_enable,
    input  wire logic        lock_to_ref_n,
    input  wire logic        loopback_select,
    input  wire logic        prbs_check_enable,
    input  wire logic        factory_test_select,
    // analog front end and decoder side
    input  wire logic        los_detect,
    input  wire logic        ref_bit_strobe,
    input  wire logic        data_bit_strobe,
    input  wire logic [15:0] dec_word,
    input  wire logic        dec_ctrl_low,
    input  wire logic        dec_ctrl_high,
    input  wire logic        prbs_match,
    input  wire logic        tx_serial_bit,
    input  wire logic        ser_in_bit,
    output logic             rx_serial_bit,
    // serial line outputs
    output logic             ser_out_pos,
    output logic             ser_out_neg,
    output logic             ser_out_oe,
    // parallel receive port
    output logic [15:0]      rx_word,
    output logic             rx_word_oe,
    output logic             rx_ctrl_char_low_flag,
    output logic             rx_ctrl_char_high_flag,
    output logic             rx_flags_oe,
    output logic             recovered_word_clock,
    output logic             recovered_word_clock_oe
);

    if (POR_LEN < 1 || POR_LEN > 65535)
    begin : g_por_len_check
        $error("POR_LEN out of range");
    end

    pwr_state_e       pwr_q;
    logic [15:0]      por_cnt_q;
    logic             en_d1_q;
    logic [1:0]       ctrl_q;
    logic [EV_W-1:0]  int_sts_q;
    logic [EV_W-1:0]  int_mask_q;
    logic [31:0]      word_cnt_q;
    logic             los_q;
    logic             prbs_ok_q;
    logic [4:0]       bit_cnt_q;
    logic             access;
    logic             wr_hit;
    logic             rd_hit;
    logic             restart;
    logic             por_done;
    logic             running;
    logic             bit_stb;
    logic             word_end;
    logic [EV_W-1:0]  ev;
    logic [EV_W-1:0]  int_clr;
    logic [31:0]      status_w;

    function automatic logic addr_ok(input logic [7:0] a);
        return a == CTRL_OFS || a == STATUS_OFS || a == INT_STS_OFS || a == INT_MASK_OFS || a == WORD_CNT_OFS;
    endfunction

    // one wait state so that read data and pready come from flops
    assign access  = psel && penable && pready;
    assign wr_hit  = access && pwrite && addr_ok(paddr);
    assign rd_hit  = access && !pwrite && addr_ok(paddr);
    assign restart = wr_hit && paddr == CTRL_OFS && pwdata[CTRL_RESTART_BIT];
    assign running = pwr_q == PWR_RUN;
    assign por_done = pwr_q == PWR_POR && por_cnt_q == 16'(POR_LEN - 1);

    // reference timing in transmit-only mode, data timing otherwise
    assign bit_stb  = running && (lock_to_ref_n ? data_bit_strobe : ref_bit_strobe); // [R01] [R03]
    assign word_end = bit_stb && bit_cnt_q == WCLK_LAST_CNT;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= psel && penable && !pready;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && penable && !pready)
        begin
            pslverr <= !addr_ok(paddr);
            prdata  <= 32'h0000_0000;
            if (!pwrite)
            begin
                unique case (paddr)
                    CTRL_OFS:     prdata <= {30'h0, ctrl_q};
                    STATUS_OFS:   prdata <= status_w;
                    INT_STS_OFS:  prdata <= {{(32-EV_W){1'b0}}, int_sts_q};
                    INT_MASK_OFS: prdata <= {{(32-EV_W){1'b0}}, int_mask_q};
                    WORD_CNT_OFS: prdata <= word_cnt_q;
                    default:      prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_comb
    begin
        status_w = 32'h0000_0000;
        status_w[ST_LOS_BIT]      = los_q;
        status_w[ST_POR_BIT]      = pwr_q == PWR_POR;
        status_w[ST_REF_LOCK_BIT] = !lock_to_ref_n;
        status_w[ST_LOOPBACK_BIT] = loopback_select;
        status_w[ST_PRBS_OK_BIT]  = prbs_ok_q;
        status_w[ST_PWRDN_BIT]    = pwr_q == PWR_DOWN;
        status_w[ST_TEST_BIT]     = factory_test_select; // [R15]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= CTRL_RESET;
        else if (wr_hit && paddr == CTRL_OFS)
            ctrl_q <= {pwdata[CTRL_TX_MUTE_BIT], 1'b0};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_mask_q <= INT_MASK_RESET;
        else if (wr_hit && paddr == INT_MASK_OFS)
            int_mask_q <= pwdata[EV_W-1:0];
    end

    // power sequencing; a software restart also reruns the power-on reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            en_d1_q <= 1'b0;
        else
            en_d1_q <= device_enable;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwr_q     <= PWR_POR;
            por_cnt_q <= 16'h0000;
        end
        else if (!device_enable)
        begin
            pwr_q     <= PWR_DOWN; // [R16]
            por_cnt_q <= 16'h0000;
        end
        else if ((device_enable && !en_d1_q) || restart)
        begin
            pwr_q     <= PWR_POR; // [R16]
            por_cnt_q <= 16'h0000;
        end
        else if (pwr_q == PWR_POR)
        begin
            por_cnt_q <= por_cnt_q + 16'h0001;
            if (por_done)
                pwr_q <= PWR_RUN;
        end
    end

    // signal detect stays alive in power-down
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            los_q <= 1'b0;
        else
            los_q <= los_detect;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prbs_ok_q <= 1'b0;
        else
            prbs_ok_q <= running && prbs_check_enable && prbs_match;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_serial_bit <= 1'b0;
        else
            rx_serial_bit <= loopback_select ? tx_serial_bit : ser_in_bit; // [R04]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ser_out_pos <= 1'b0;
            ser_out_neg <= 1'b1;
            ser_out_oe  <= 1'b0;
        end
        else
        begin
            ser_out_pos <= tx_serial_bit;
            ser_out_neg <= !tx_serial_bit;
            ser_out_oe  <= running && !loopback_select && !ctrl_q[CTRL_TX_MUTE_BIT]; // [R05]
        end
    end

    // divide the bit strobe by twenty: rise after bit 9, fall and reload after bit 19
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bit_cnt_q <= 5'h00;
        else if (!running)
            bit_cnt_q <= 5'h00;
        else if (bit_stb)
            bit_cnt_q <= word_end ? 5'h00 : bit_cnt_q + 5'h01; // [R11]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            recovered_word_clock <= 1'b0;
        else if (!running)
            recovered_word_clock <= 1'b0; // [R12]
        else if (bit_stb && bit_cnt_q == WCLK_RISE_CNT)
            recovered_word_clock <= 1'b1; // [R11] [R13]
        else if (word_end)
            recovered_word_clock <= 1'b0;
    end

    // word changes on the falling clock so it is stable half a word before the rise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_word                <= 16'h0000;
            rx_ctrl_char_low_flag  <= 1'b0;
            rx_ctrl_char_high_flag <= 1'b0;
        end
        else if (los_q)
        begin
            rx_word                <= LOS_WORD; // [R10] [R18]
            rx_ctrl_char_low_flag  <= 1'b1;
            rx_ctrl_char_high_flag <= 1'b1;
        end
        else if (word_end)
        begin
            rx_word                <= dec_word; // [R13]
            rx_ctrl_char_low_flag  <= prbs_check_enable ? prbs_ok_q : dec_ctrl_low; // [R07] [R08]
            rx_ctrl_char_high_flag <= dec_ctrl_high; // [R09]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_word_oe              <= 1'b0;
            rx_flags_oe             <= 1'b0;
            recovered_word_clock_oe <= 1'b0;
        end
        else
        begin
            rx_word_oe              <= running && lock_to_ref_n; // [R02] [R14]
            rx_flags_oe             <= running && lock_to_ref_n; // [R02]
            recovered_word_clock_oe <= pwr_q != PWR_DOWN && lock_to_ref_n; // [R02] [R12]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            word_cnt_q <= 32'h0000_0000;
        else if (word_end && lock_to_ref_n)
            word_cnt_q <= word_cnt_q + 32'h0000_0001;
    end

    always_comb
    begin
        ev = '0;
        ev[EV_LOS_SET_BIT]   = los_detect && !los_q;
        ev[EV_LOS_CLR_BIT]   = !los_detect && los_q;
        ev[EV_PRBS_FAIL_BIT] = prbs_ok_q && !(running && prbs_check_enable && prbs_match);
        ev[EV_POR_DONE_BIT]  = por_done && device_enable && en_d1_q && !restart;
        int_clr = (rd_hit && paddr == INT_STS_OFS) ? prdata[EV_W-1:0] : '0;
    end

    // only bits already returned are cleared; a new event in the clearing read's cycle survives
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_sts_q <= '0;
        else
            int_sts_q <= (int_sts_q & ~int_clr) | ev;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(((int_sts_q & ~int_clr) | ev) & int_mask_q);
    end

endmodule // serdes_rx_port

// ### dv/serdes_rx_port_properties.sv
module serdes_rx_port_properties
    import serdes_rx_pkg::*;
#(
    parameter int POR_LEN = POR_CYCLES
)
(
    input wire logic        pclk, presetn, psel, penable, pready, device_enable, lock_to_ref_n,
    input wire logic        loopback_select, prbs_check_enable, los_detect, dec_ctrl_low, dec_ctrl_high,
    input wire logic        tx_serial_bit, ser_in_bit, rx_serial_bit, ser_out_oe, rx_word_oe, rx_flags_oe,
    input wire logic        rx_ctrl_char_low_flag, rx_ctrl_char_high_flag,
    input wire logic        recovered_word_clock, recovered_word_clock_oe,
    input wire logic [15:0] dec_word, rx_word
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] por_q;
    logic       en_prev_q;
    // cycles of power-on reset still to run after enable rises or reset ends
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            por_q     <= 8'h00;
            en_prev_q <= 1'b0;
        end
        else
        begin
            en_prev_q <= device_enable;
            if (device_enable && !en_prev_q)
                por_q <= 8'(POR_LEN);
            else if (por_q != 8'h00)
                por_q <= por_q - 8'h01;
        end
    // a fall forced by power-down, or one during loss, carries no fresh word
    sequence word_end;
        $fell(recovered_word_clock) && device_enable && !$past(los_detect) && !$past(los_detect, 2);
    endsequence
    AST_REF_HIZ: assert property (!lock_to_ref_n |=>
        !rx_word_oe && !rx_flags_oe && !recovered_word_clock_oe) else $error("port driven");
    AST_LOOP_ROUTE: assert property (loopback_select |=> rx_serial_bit == $past(tx_serial_bit))
        else $error("loop path");
    AST_LINE_ROUTE: assert property (!loopback_select |=> rx_serial_bit == $past(ser_in_bit))
        else $error("line path");
    AST_LOOP_TX_OFF: assert property (loopback_select |=> !ser_out_oe) else $error("tx driven");
    AST_LOS_FORCE: assert property (los_detect [*2] |=>
        rx_word == LOS_WORD && rx_ctrl_char_low_flag && rx_ctrl_char_high_flag) else $error("loss force");
    AST_POR_QUIET: assert property (por_q != 8'h00 |-> !recovered_word_clock && !rx_word_oe)
        else $error("por outputs");
    AST_PWRDN_QUIET: assert property (!device_enable [*3] |->
        !recovered_word_clock && !recovered_word_clock_oe) else $error("power-down clock");
    AST_WORD_LOAD: assert property (word_end |->
        rx_word == $past(dec_word) && rx_ctrl_char_high_flag == $past(dec_ctrl_high)) else $error("word load");
    AST_LOW_FLAG: assert property (word_end and !$past(prbs_check_enable) |->
        rx_ctrl_char_low_flag == $past(dec_ctrl_low)) else $error("low flag");
    AST_APB_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("apb wait");
    cover property (los_detect [*2]);
    cover property (word_end);
    cover property (loopback_select ##1 !loopback_select);
endmodule // serdes_rx_port_properties

// ### dv/rx_protocol_dev.sv
module rx_protocol_dev
(
    input  wire logic        recovered_word_clock, recovered_word_clock_oe, rx_word_oe, rx_flags_oe,
    input  wire logic        rx_ctrl_char_low_flag, rx_ctrl_char_high_flag,
    input  wire logic [15:0] rx_word,
    output logic      [17:0] cap_q,
    output int               cap_cnt,
    output int               period_ns
);
    timeunit 1ns;
    timeprecision 100ps;
    int last_t = 0;
    initial
    begin
        cap_q = 18'h00000;
        cap_cnt = 0;
        period_ns = 0;
    end
    // an undriven bus is never taken: a shared bus may belong to the other port
    always @(posedge recovered_word_clock)
        if (recovered_word_clock_oe && rx_word_oe && rx_flags_oe)
        begin
            cap_q <= {rx_ctrl_char_high_flag, rx_ctrl_char_low_flag, rx_word};
            period_ns <= int'($time) - last_t;
            last_t = int'($time);
            cap_cnt <= cap_cnt + 1;
        end
endmodule // rx_protocol_dev

// ### dv/tb_serdes_rx_port.sv
module tb_serdes_rx_port
    import serdes_rx_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int POR_LEN = 2;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, pready, pslverr, irq;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        device_enable = 1'b1, lock_to_ref_n = 1'b1, loopback_select = 1'b0, prbs_check_enable = 1'b0;
    logic        factory_test_select = 1'b0;
    logic        los_detect = 1'b0, ref_bit_strobe = 1'b1, data_bit_strobe = 1'b1, seen = 1'b0;
    logic        dec_ctrl_low = 1'b0, dec_ctrl_high = 1'b0, prbs_match = 1'b0, tx_serial_bit = 1'b0;
    logic        ser_in_bit = 1'b0, rx_serial_bit, ser_out_pos, ser_out_neg, ser_out_oe, rx_word_oe, rx_flags_oe;
    logic        rx_ctrl_char_low_flag, rx_ctrl_char_high_flag, recovered_word_clock, recovered_word_clock_oe;
    logic [15:0] dec_word = 16'h0, rx_word;
    logic [17:0] cap_q;
    int          cap_cnt, period_ns, error_cnt = 0, samples_checked = 0, n0;
    always #50 pclk = ~pclk;
    serdes_rx_port #(.POR_LEN(POR_LEN)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq, .device_enable, .lock_to_ref_n, .loopback_select, .prbs_check_enable,
        .factory_test_select, .los_detect, .ref_bit_strobe, .data_bit_strobe, .dec_word, .dec_ctrl_low,
        .dec_ctrl_high, .prbs_match, .tx_serial_bit, .ser_in_bit, .rx_serial_bit, .ser_out_pos, .ser_out_neg,
        .ser_out_oe, .rx_word, .rx_word_oe, .rx_ctrl_char_low_flag, .rx_ctrl_char_high_flag, .rx_flags_oe,
        .recovered_word_clock, .recovered_word_clock_oe);
    rx_protocol_dev far_end (.recovered_word_clock, .recovered_word_clock_oe, .rx_word_oe, .rx_flags_oe,
        .rx_ctrl_char_low_flag, .rx_ctrl_char_high_flag, .rx_word, .cap_q, .cap_cnt, .period_ns);
    task automatic end_sim();
        $display("mismatches %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            error_cnt++;
            $display("Error at %0t: bus hung", $time);
            end_sim();
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // waits for k more words taken by the protocol device
    task automatic words(input int k);
        int t;
        t = cap_cnt + k;
        for (int i = 0; i < 100 * k && cap_cnt < t; i++)
            @(posedge pclk);
        if (cap_cnt < t)
        begin
            error_cnt++;
            $display("Error at %0t: no word", $time);
            end_sim();
        end
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(INT_MASK_OFS, 32'h0);
        apb(1'b1, INT_MASK_OFS, 32'h1);
        rdchk(INT_MASK_OFS, 32'h1);
        rdchk(8'h14, 32'h0);
        chk(err, 1'b1);
        $display("registers done");
        for (int i = 0; i < 2; i++)
        begin
            dec_word <= i ? 16'h3C5A : 16'hA5C3;
            dec_ctrl_low <= (i == 0);
            dec_ctrl_high <= (i == 1);
            words(2);
            chk(cap_q, {i == 1, i == 0, i ? 16'h3C5A : 16'hA5C3});
        end
        chk(period_ns, BITS_PER_WORD * 100);
        prbs_check_enable <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            prbs_match <= (i == 0);
            words(2);
            chk(cap_q[16], i == 0);
        end
        $display("word path done");
        apb(1'b0, INT_STS_OFS, 32'h0);
        los_detect <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({rx_ctrl_char_high_flag, rx_ctrl_char_low_flag, rx_word}, 18'h3FFFF);
        chk(irq, 1'b1);
        rdchk(INT_STS_OFS, 32'h1);
        los_detect <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        $display("loss done");
        lock_to_ref_n <= 1'b0;
        data_bit_strobe <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({rx_word_oe, rx_flags_oe, recovered_word_clock_oe}, 3'b000);
        rdchk(STATUS_OFS, 32'h4);
        // no data strobes: only the reference can keep the word clock running
        for (int i = 0; i < 25; i++)
        begin
            @(posedge pclk);
            seen |= recovered_word_clock;
        end
        chk(seen, 1'b1);
        lock_to_ref_n <= 1'b1;
        n0 = cap_cnt;
        repeat (45) @(posedge pclk);
        chk(cap_cnt, n0);
        apb(1'b0, WORD_CNT_OFS, 32'h0);
        n0 = rd;
        data_bit_strobe <= 1'b1;
        repeat (40) @(posedge pclk);
        data_bit_strobe <= 1'b0;
        rdchk(WORD_CNT_OFS, n0 + 2);
        data_bit_strobe <= 1'b1;
        loopback_select <= 1'b1;
        tx_serial_bit <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({rx_serial_bit, ser_out_oe}, 2'b10);
        loopback_select <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({rx_serial_bit, ser_out_oe, ser_out_pos, ser_out_neg}, 4'b0110);
        apb(1'b1, CTRL_OFS, 32'h2);
        rdchk(CTRL_OFS, 32'h2);
        chk(ser_out_oe, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h0);
        $display("modes done");
        device_enable <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({recovered_word_clock, recovered_word_clock_oe}, 2'b00);
        rdchk(STATUS_OFS, 32'h20);
        device_enable <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({rx_word_oe, recovered_word_clock}, 2'b00);
        words(2);
        chk(cap_q[15:0], 16'h3C5A);
        $display("power-down done");
        end_sim();
    end
endmodule // tb_serdes_rx_port

bind serdes_rx_port serdes_rx_port_properties #(.POR_LEN(POR_LEN)) props (.pclk, .presetn, .psel, .penable,
    .pready, .device_enable, .lock_to_ref_n, .loopback_select, .prbs_check_enable, .los_detect, .dec_ctrl_low,
    .dec_ctrl_high, .tx_serial_bit, .ser_in_bit, .rx_serial_bit, .ser_out_oe, .rx_word_oe, .rx_flags_oe,
    .rx_ctrl_char_low_flag, .rx_ctrl_char_high_flag, .recovered_word_clock, .recovered_word_clock_oe,
    .dec_word, .rx_word);
